// *** rcsc_pkg.sv ***
// Package of constants and types for the rotary cutter sync control block
package rcsc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_CUT_LEN   = 4'h1;
  localparam logic [3:0] REG_CIRC      = 4'h2;
  localparam logic [3:0] REG_ZONE_BEF  = 4'h3;
  localparam logic [3:0] REG_ZONE_AFT  = 4'h4;
  localparam logic [3:0] REG_VM_SPEED  = 4'h5;
  localparam logic [3:0] REG_HOME_SPD  = 4'h6;
  localparam logic [3:0] REG_JOG_SPD   = 4'h7;
  localparam logic [3:0] REG_GAIN      = 4'h8;
  localparam logic [3:0] REG_STATUS    = 4'h9;
  localparam logic [3:0] REG_MPOS      = 4'hA;
  localparam logic [3:0] REG_RPOS      = 4'hB;
  localparam logic [3:0] REG_SPEED_OUT = 4'hC;
  // Control register fields
  localparam int CTRL_MMUL_LSB = 0;
  localparam int CTRL_SMUL_LSB = 2;
  localparam int CTRL_LINEAR   = 4;
  localparam int CTRL_VIRT_SEL = 5;
  // Edge multiplication codes
  localparam logic [1:0] MUL_X1 = 2'h0;
  localparam logic [1:0] MUL_X2 = 2'h1;
  localparam logic [1:0] MUL_X4 = 2'h2;
  // Reset values
  localparam logic [31:0] CUT_LEN_RST = 32'h0000_1000;
  localparam logic [31:0] CIRC_RST    = 32'h0000_1000;
  localparam logic [31:0] ZONE_RST    = 32'h0000_0100;
  localparam logic [31:0] SPEED_RST   = 32'h0000_0010;
  localparam logic [31:0] GAIN_RST    = 32'h0000_0004;
  // Control loop cycle time
  localparam int CLK_NS        = 4;
  localparam int LOOP_CYCLE_US = 1;
  localparam int LOOP_CYCLES   = (LOOP_CYCLE_US * 1000) / CLK_NS;
  // Jerk step of the S ramp per loop cycle
  localparam logic [15:0] JERK_STEP = 16'h0001;
  typedef enum logic [2:0] {RCSC_IDLE, RCSC_HOLD, RCSC_JOG, RCSC_HOME_SEEK, RCSC_HOME_MOVE,
                            RCSC_AUTO} rcsc_state_type;
endpackage : rcsc_pkg

// *** rcsc_quad.sv ***
// Quadrature decoder with selectable x1/x2/x4 edge multiplication
`timescale 1ns/1ps
module rcsc_quad
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clear,
  input  wire logic        a,
  input  wire logic        b,
  input  wire logic [1:0]  mul,
  output logic             step,
  output logic             dir_up
);
  logic [1:0] prev;
  logic [1:0] next_prev;
  logic       next_step;
  logic       next_dir_up;
  logic       edge_a;
  logic       edge_b;
  logic       fwd;

  // Decode direction and qualify the edge by the selected factor
  always_comb
  begin
    edge_a      = a ^ prev[1];
    edge_b      = b ^ prev[0];
    fwd         = edge_a ? (a ^ b) : ~(a ^ b);
    next_prev   = {a, b};
    next_dir_up = fwd;                                           // A leading B counts up
    case (mul)
      rcsc_pkg::MUL_X1: next_step = edge_a & a;
      rcsc_pkg::MUL_X2: next_step = edge_a;
      default:          next_step = edge_a | edge_b;
    endcase
    if (edge_a && edge_b)
      next_step = 1'b0;  // Illegal double transition, dropped
    if (clear)
      next_step = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prev   <= 2'h0;
      step   <= 1'b0;
      dir_up <= 1'b0;
    end
    else
    begin
      prev   <= next_prev;
      step   <= next_step;
      dir_up <= next_dir_up;
    end
  end
endmodule : rcsc_quad

// *** rcsc_top.sv ***
// Rotary cutter synchronising controller: position loop, zone profile, homing, jog
`timescale 1ns/1ps
module rcsc_top
#(
  parameter int LOOP_CYCLES = rcsc_pkg::LOOP_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        enable,
  input  wire logic        auto_run,
  input  wire logic        enc1_a,
  input  wire logic        enc1_b,
  input  wire logic        enc2_a,
  input  wire logic        enc2_b,
  input  wire logic        cut_pulse,
  input  wire logic        trim_fwd,
  input  wire logic        trim_rev,
  input  wire logic        home_start,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic [15:0]      ana_out2,
  output logic             in_sync_zone,
  output logic             home_done
);
  // Tick counter is 16 bits wide and needs at least two phases per loop cycle
  if (LOOP_CYCLES < 2 || LOOP_CYCLES > 65536)
  begin : g_bad_loop
    $error("LOOP_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [5:0]  ctrl;
  logic [31:0] cut_len;
  logic [31:0] circ;
  logic [31:0] zone_bef;
  logic [31:0] zone_aft;
  logic [15:0] vm_speed;
  logic [15:0] home_spd;
  logic [15:0] jog_spd;
  logic [15:0] gain;
  logic [5:0]  next_ctrl;
  logic [31:0] next_cut_len;
  logic [31:0] next_circ;
  logic [31:0] next_zone_bef;
  logic [31:0] next_zone_aft;
  logic [15:0] next_vm_speed;
  logic [15:0] next_home_spd;
  logic [15:0] next_jog_spd;
  logic [15:0] next_gain;
  logic [31:0] next_rdata;
  logic        virt_active;
  logic        next_virt_active;
  logic        home_done_r;
  logic signed [31:0] mpos;
  logic signed [31:0] rpos;
  logic signed [15:0] speed_cmd;
  rcsc_pkg::rcsc_state_type state;

  // Register writes and read mux; unmapped reads return zero
  always_comb
  begin
    next_ctrl     = ctrl;
    next_cut_len  = cut_len;
    next_circ     = circ;
    next_zone_bef = zone_bef;
    next_zone_aft = zone_aft;
    next_vm_speed = vm_speed;
    next_home_spd = home_spd;
    next_jog_spd  = jog_spd;
    next_gain     = gain;
    if (reg_wr)
    begin
      case (reg_addr)
        rcsc_pkg::REG_CTRL:     next_ctrl     = reg_wdata[5:0];
        rcsc_pkg::REG_CUT_LEN:  next_cut_len  = reg_wdata;
        rcsc_pkg::REG_CIRC:     next_circ     = reg_wdata;
        rcsc_pkg::REG_ZONE_BEF: next_zone_bef = reg_wdata;
        rcsc_pkg::REG_ZONE_AFT: next_zone_aft = reg_wdata;
        rcsc_pkg::REG_VM_SPEED: next_vm_speed = reg_wdata[15:0];
        rcsc_pkg::REG_HOME_SPD: next_home_spd = reg_wdata[15:0];
        rcsc_pkg::REG_JOG_SPD:  next_jog_spd  = reg_wdata[15:0];
        rcsc_pkg::REG_GAIN:     next_gain     = reg_wdata[15:0];
        default:                next_ctrl     = ctrl;
      endcase
    end
    next_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        rcsc_pkg::REG_CTRL:      next_rdata = {26'h0, ctrl};
        rcsc_pkg::REG_CUT_LEN:   next_rdata = cut_len;
        rcsc_pkg::REG_CIRC:      next_rdata = circ;
        rcsc_pkg::REG_ZONE_BEF:  next_rdata = zone_bef;
        rcsc_pkg::REG_ZONE_AFT:  next_rdata = zone_aft;
        rcsc_pkg::REG_VM_SPEED:  next_rdata = {16'h0, vm_speed};
        rcsc_pkg::REG_HOME_SPD:  next_rdata = {16'h0, home_spd};
        rcsc_pkg::REG_JOG_SPD:   next_rdata = {16'h0, jog_spd};
        rcsc_pkg::REG_GAIN:      next_rdata = {16'h0, gain};
        rcsc_pkg::REG_STATUS:    next_rdata = {25'h0, state, virt_active, home_done_r, in_sync_zone, enable};
        rcsc_pkg::REG_MPOS:      next_rdata = mpos;
        rcsc_pkg::REG_RPOS:      next_rdata = rpos;
        rcsc_pkg::REG_SPEED_OUT: next_rdata = {{16{speed_cmd[15]}}, speed_cmd};
        default:                 next_rdata = 32'h0000_0000;
      endcase
    end
    // Selection latches only while automatic operation is off
    next_virt_active = virt_active;
    if (!auto_run)
      next_virt_active = ctrl[rcsc_pkg::CTRL_VIRT_SEL];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl        <= 6'h00;
      cut_len     <= rcsc_pkg::CUT_LEN_RST;
      circ        <= rcsc_pkg::CIRC_RST;
      zone_bef    <= rcsc_pkg::ZONE_RST;
      zone_aft    <= rcsc_pkg::ZONE_RST;
      vm_speed    <= rcsc_pkg::SPEED_RST[15:0];
      home_spd    <= rcsc_pkg::SPEED_RST[15:0];
      jog_spd     <= rcsc_pkg::SPEED_RST[15:0];
      gain        <= rcsc_pkg::GAIN_RST[15:0];
      reg_rdata   <= 32'h0000_0000;
      virt_active <= 1'b0;
    end
    else
    begin
      ctrl        <= next_ctrl;
      cut_len     <= next_cut_len;
      circ        <= next_circ;
      zone_bef    <= next_zone_bef;
      zone_aft    <= next_zone_aft;
      vm_speed    <= next_vm_speed;
      home_spd    <= next_home_spd;
      jog_spd     <= next_jog_spd;
      gain        <= next_gain;
      reg_rdata   <= next_rdata;
      virt_active <= next_virt_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Encoder decoding: line on input one, roll on input two
  logic       m_step;
  logic       m_up;
  logic       r_step;
  logic       r_up;
  logic       clr;
  assign clr = ~enable;

  rcsc_quad u_enc_line
  (
    .clk    (clk),
    .srst   (srst),
    .clear  (clr),
    .a      (enc1_a),
    .b      (enc1_b),
    .mul    (ctrl[rcsc_pkg::CTRL_MMUL_LSB +: 2]),
    .step   (m_step),
    .dir_up (m_up)
  );

  rcsc_quad u_enc_roll
  (
    .clk    (clk),
    .srst   (srst),
    .clear  (clr),
    .a      (enc2_a),
    .b      (enc2_b),
    .mul    (ctrl[rcsc_pkg::CTRL_SMUL_LSB +: 2]),
    .step   (r_step),
    .dir_up (r_up)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Loop tick, virtual master, position counters and cut-point tracking
  logic [15:0] tick_cnt;
  logic        tick;
  logic [15:0] vm_acc;
  logic signed [31:0] ref_pos;
  logic signed [31:0] cut_ref;
  logic        cut_prev;
  logic        cut_rise;
  logic signed [31:0] rel_roll;
  logic [15:0] next_tick_cnt;
  logic [15:0] next_vm_acc;
  logic signed [31:0] next_mpos;
  logic signed [31:0] next_rpos;
  logic signed [31:0] next_cut_ref;
  logic        vm_step;

  // Position counters step by direction; enable low holds all but cut_prev in reset
  always_comb
  begin
    next_tick_cnt = (tick_cnt == 16'(LOOP_CYCLES - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
    tick          = (tick_cnt == 16'h0000);
    {vm_step, next_vm_acc} = {1'b0, vm_acc} + {1'b0, vm_speed};
    cut_rise  = cut_pulse & ~cut_prev;
    next_mpos = mpos;
    if (virt_active ? vm_step : (m_step && !virt_active))
      next_mpos = (virt_active || m_up) ? mpos + 32'sd1 : mpos - 32'sd1;
    next_rpos = rpos;
    if (r_step)
      next_rpos = r_up ? rpos + 32'sd1 : rpos - 32'sd1;
    next_cut_ref = cut_ref;
    if (cut_rise)
      next_cut_ref = rpos;
    if (!enable)
    begin
      next_tick_cnt = 16'h0000;
      next_vm_acc   = 16'h0000;
      next_mpos     = 32'sd0;
      next_rpos     = 32'sd0;
      next_cut_ref  = 32'sd0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tick_cnt <= 16'h0000;
      vm_acc   <= 16'h0000;
      mpos     <= 32'sd0;
      rpos     <= 32'sd0;
      cut_ref  <= 32'sd0;
      cut_prev <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      vm_acc   <= next_vm_acc;
      mpos     <= next_mpos;
      rpos     <= next_rpos;
      cut_ref  <= next_cut_ref;
      cut_prev <= cut_pulse;
    end
  end

  // Roll offset within the revolution relative to the cut edge
  assign rel_roll = rpos - cut_ref;

  ////////////////////////////////////////////////////////////////////////////
  // Operating state machine, profile and position loop
  rcsc_pkg::rcsc_state_type next_state;
  logic signed [15:0] next_speed_cmd;
  logic signed [15:0] accel;
  logic signed [15:0] next_accel;
  logic signed [31:0] next_ref_pos;
  logic               next_home_done;
  logic               sync_now;
  logic signed [31:0] err;
  logic signed [31:0] ff_speed;
  logic signed [31:0] target;
  logic signed [31:0] diff;
  logic signed [31:0] home_tgt;

  always_comb
  begin
    sync_now  = (rel_roll >= -$signed(zone_bef)) && (rel_roll <= $signed(zone_aft));
    home_tgt  = $signed(circ >> 1) + ($signed(zone_aft) - $signed(zone_bef)) / 2;
    err       = ref_pos - rpos;
    next_state     = state;
    next_ref_pos   = ref_pos;
    next_home_done = home_done_r;
    ff_speed       = 32'sd0;
    case (state)
      rcsc_pkg::RCSC_IDLE: next_state = rcsc_pkg::RCSC_HOLD;
      rcsc_pkg::RCSC_HOLD:
      begin
        if (auto_run)
          next_state = rcsc_pkg::RCSC_AUTO;
        else if (home_start)
          next_state = rcsc_pkg::RCSC_HOME_SEEK;
        else if (trim_fwd || trim_rev)
          next_state = rcsc_pkg::RCSC_JOG;
      end
      rcsc_pkg::RCSC_JOG:
      begin
        // Jog moves the reference; release holds the new position
        if (tick)
          next_ref_pos = trim_fwd ? ref_pos + $signed({16'h0, jog_spd}) :
                         trim_rev ? ref_pos - $signed({16'h0, jog_spd}) : ref_pos;
        next_home_done = 1'b0;
        if (!trim_fwd && !trim_rev)
          next_state = rcsc_pkg::RCSC_HOLD;
      end
      rcsc_pkg::RCSC_HOME_SEEK:
      begin
        if (tick)
          next_ref_pos = ref_pos + $signed({16'h0, home_spd});
        if (cut_rise)
          next_state = rcsc_pkg::RCSC_HOME_MOVE;
      end
      rcsc_pkg::RCSC_HOME_MOVE:
      begin
        if (tick && (ref_pos - cut_ref < home_tgt))
          next_ref_pos = ref_pos + $signed({16'h0, home_spd});
        else if (ref_pos - cut_ref >= home_tgt)
        begin
          next_ref_pos   = cut_ref + home_tgt;
          next_home_done = 1'b1;
          next_state     = rcsc_pkg::RCSC_HOLD;
        end
      end
      rcsc_pkg::RCSC_AUTO:
      begin
        next_home_done = 1'b0;
        if (virt_active ? vm_step : m_step)
        begin
          // Sync zone and async alike: one roll count per line count; async scaling comes from ff_speed
          if (sync_now)
            next_ref_pos = ref_pos + 32'sd1;
          else
            next_ref_pos = ref_pos + 32'sd1;
        end
        if (tick && trim_fwd)
          next_ref_pos = next_ref_pos + 32'sd1;
        else if (tick && trim_rev)
          next_ref_pos = next_ref_pos - 32'sd1;
        if (!auto_run)
          next_state = rcsc_pkg::RCSC_HOLD;
      end
      default: next_state = rcsc_pkg::RCSC_IDLE;
    endcase
    // Async target speed: circ/len ratio >1 when cut shorter than circumference
    if (state == rcsc_pkg::RCSC_AUTO && !sync_now)
      ff_speed = $signed({16'h0, vm_speed}) * $signed(circ) / $signed((cut_len == 32'h0) ? 32'h1 : cut_len)
                 - $signed({16'h0, vm_speed});
    // Position loop with profile feed-forward, evaluated each loop tick
    target = err * $signed({16'h0, gain}) + ff_speed;
    if (target < 32'sd0 && state == rcsc_pkg::RCSC_AUTO && !sync_now && ff_speed < 32'sd0 && err <= 32'sd0)
      target = 32'sd0;
    diff = target - 32'(speed_cmd);
    next_accel     = accel;
    next_speed_cmd = speed_cmd;
    if (tick)
    begin
      if (ctrl[rcsc_pkg::CTRL_LINEAR])
      begin
        next_accel     = 16'sd0;
        next_speed_cmd = (diff > 32'sd0) ? speed_cmd + 16'sd1 :
                         (diff < 32'sd0) ? speed_cmd - 16'sd1 : speed_cmd;
      end
      else
      begin
        // Jerk-limited: accel grows toward the gap and shrinks as it closes
        if (diff > 32'(accel) * 32'(accel) / 2 && accel < 16'sh4000)
          next_accel = accel + $signed(rcsc_pkg::JERK_STEP);
        else if (diff < -(32'(accel) * 32'(accel) / 2) && accel > -16'sh4000)
          next_accel = accel - $signed(rcsc_pkg::JERK_STEP);
        else if (accel > 16'sd0)
          next_accel = accel - $signed(rcsc_pkg::JERK_STEP);
        else if (accel < 16'sd0)
          next_accel = accel + $signed(rcsc_pkg::JERK_STEP);
        next_speed_cmd = speed_cmd + next_accel;
      end
    end
    if (!enable)
    begin
      next_state     = rcsc_pkg::RCSC_IDLE;
      next_ref_pos   = 32'sd0;
      next_accel     = 16'sd0;
      next_speed_cmd = 16'sd0;
      next_home_done = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state        <= rcsc_pkg::RCSC_IDLE;
      ref_pos      <= 32'sd0;
      accel        <= 16'sd0;
      speed_cmd    <= 16'sd0;
      home_done_r  <= 1'b0;
      ana_out2     <= 16'h0000;
      in_sync_zone <= 1'b0;
      home_done    <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      ref_pos      <= next_ref_pos;
      accel        <= next_accel;
      speed_cmd    <= next_speed_cmd;
      home_done_r  <= next_home_done;
      ana_out2     <= enable ? next_speed_cmd : 16'h0000;
      in_sync_zone <= enable & sync_now;
      home_done    <= next_home_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_enable_drop;
    !enable;
  endsequence

  a_disable_zeroes: assert property (@(posedge clk) disable iff (srst)
    s_enable_drop |=> (ana_out2 == 16'h0000 && mpos == 32'sd0 && rpos == 32'sd0))
    else $error("outputs or counters not cleared while disabled");
  a_virt_hold: assert property (@(posedge clk) disable iff (srst)
    auto_run && $past(auto_run) |-> $stable(virt_active))
    else $error("master source changed during automatic run");
  a_roll_count: assert property (@(posedge clk) disable iff (srst)
    enable && $past(enable) && $past(r_step) && $past(r_up) |-> rpos == $past(rpos) + 32'sd1)
    else $error("roll counter did not step up");
  a_sync_flag: assert property (@(posedge clk) disable iff (srst)
    enable && sync_now |=> in_sync_zone)
    else $error("sync zone flag missing");
  a_speed_tick: assert property (@(posedge clk) disable iff (srst)
    enable && !tick |=> $stable(speed_cmd))
    else $error("speed changed off loop cycle");
  a_linear_step: assert property (@(posedge clk) disable iff (srst)
    enable && tick && ctrl[rcsc_pkg::CTRL_LINEAR] |=> (speed_cmd - $past(speed_cmd) <= 16'sd1)
      && ($past(speed_cmd) - speed_cmd <= 16'sd1))
    else $error("linear ramp step too large");
  a_home_done: assert property (@(posedge clk) disable iff (srst)
    $rose(home_done_r) |-> $past(state) == rcsc_pkg::RCSC_HOME_MOVE)
    else $error("home done outside homing move");
  a_jog_entry: assert property (@(posedge clk) disable iff (srst)
    enable && state == rcsc_pkg::RCSC_HOLD && !auto_run && !home_start && trim_fwd |=>
      state == rcsc_pkg::RCSC_JOG)
    else $error("jog not entered at standstill");
endmodule : rcsc_top

// *** rcsc_enc_model.sv ***
// Quadrature encoder model standing in for the line and roll encoders
`timescale 1ns/1ps
module rcsc_enc_model
#(
  parameter int GAP = 160
)
(
  input  wire logic clk,
  input  wire logic run,
  input  wire logic rev,
  output logic      a,
  output logic      b
);
  logic [1:0] ph = 2'h0;
  int         cnt = 0;
  // One phase step per GAP clocks keeps the edge rate near 1.56 MHz
  always @(posedge clk)
  begin
    cnt <= (!run || cnt == GAP - 1) ? 0 : cnt + 1;
    if (run && cnt == GAP - 1)
      ph <= rev ? ph - 2'h1 : ph + 2'h1;
  end
  // Gray order on the pair, A leads B going forward
  assign a = ph[0] ^ ph[1];
  assign b = ph[1];
endmodule : rcsc_enc_model

// *** tb_top.sv ***
// Self-checking testbench for the rotary cutter sync control block
`timescale 1ns/1ps
module tb_top;
  localparam int GAP = 160;
  localparam int EDG = 16;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        enable = 1'b0;
  logic        auto_run = 1'b0;
  logic        enc1_a, enc1_b, enc2_a, enc2_b;
  logic        cut_pulse = 1'b0;
  logic        trim_fwd = 1'b0;
  logic        trim_rev = 1'b0;
  logic        home_start = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] ana_out2;
  logic        in_sync_zone, home_done;
  logic        run1 = 1'b0;
  logic        run2 = 1'b0;
  logic [31:0] v, d;
  int          n_errors = 0;
  int          num_checks = 0;
  always #2 clk = ~clk;
  rcsc_top #(.LOOP_CYCLES(4)) u_rcsc_top (.clk(clk), .srst(srst), .enable(enable), .auto_run(auto_run),
    .enc1_a(enc1_a), .enc1_b(enc1_b), .enc2_a(enc2_a), .enc2_b(enc2_b), .cut_pulse(cut_pulse),
    .trim_fwd(trim_fwd), .trim_rev(trim_rev), .home_start(home_start), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ana_out2(ana_out2), .in_sync_zone(in_sync_zone), .home_done(home_done));
  rcsc_enc_model #(.GAP(GAP)) u_rcsc_enc_model (.clk(clk), .run(run1), .rev(1'b0), .a(enc1_a), .b(enc1_b));
  rcsc_enc_model #(.GAP(GAP)) u_rcsc_enc_model2 (.clk(clk), .run(run2), .rev(1'b1), .a(enc2_a), .b(enc2_b));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Bus cycles: one-cycle strobes, read data sampled in the following cycle
  task automatic wr(logic [3:0] ad, logic [31:0] wd);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] ad, output logic [31:0] rv);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
    @(posedge clk);
  endtask : rd
  function automatic logic [31:0] rst_val(logic [3:0] ad);
    case (ad)
      4'h1: return rcsc_pkg::CUT_LEN_RST;
      4'h2: return rcsc_pkg::CIRC_RST;
      4'h3, 4'h4: return rcsc_pkg::ZONE_RST;
      4'h5, 4'h6, 4'h7: return rcsc_pkg::SPEED_RST;
      4'h8: return rcsc_pkg::GAIN_RST;
      default: return 32'h0;
    endcase
  endfunction : rst_val
  // Expected count for EDG quadrature edges at multiplication code m
  function automatic logic [31:0] exp_cnt(int m, bit down);
    int n;
    n = (m == 0) ? EDG / 4 : (m == 1) ? EDG / 2 : EDG;
    return down ? -n : n;
  endfunction : exp_cnt
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well beyond the expected run of about 11k cycles
  initial
  begin
    #200000;
    n_errors++;
    final_report();
  end
  initial
  begin
    void'($urandom(35));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    enable <= 1'b1;
    // Reset values, read-only and unmapped places skipped or read as zero
    for (int i = 0; i < 16; i++)
      if (i < 9 || i > 12)
      begin
        rd(i[3:0], v);
        check("reset value", v, rst_val(i[3:0]));
      end
    // Random writes back to back with reads; an unmapped write is ignored
    for (int i = 1; i < 9; i++)
    begin
      d = {24'h0, 8'($urandom_range(255, 1))};
      wr(i[3:0], d);
      wr(4'hD, d);
      rd(i[3:0], v);
      check("readback", v, d);
      rd(4'hD, v);
      check("unmapped", v, 32'h0);
      wr(i[3:0], rst_val(i[3:0]));
    end
    $display("test registers done");
    // Each multiplication on both channels, counters cleared by enable
    for (int m = 0; m < 3; m++)
    begin
      enable <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("ana_out2 off", {16'h0, ana_out2}, 32'h0);
      rd(rcsc_pkg::REG_MPOS, v);
      check("mpos cleared", v, 32'h0);
      enable <= 1'b1;
      wr(rcsc_pkg::REG_CTRL, {28'h0, 2'(m), 2'(m)});
      run1 <= 1'b1;
      run2 <= 1'b1;
      repeat (EDG * GAP) @(posedge clk);
      run1 <= 1'b0;
      run2 <= 1'b0;
      repeat (4) @(posedge clk);
      rd(rcsc_pkg::REG_MPOS, v);
      check("mpos", v, exp_cnt(m, 1'b0));
      rd(rcsc_pkg::REG_RPOS, v);
      check("rpos", v, exp_cnt(m, 1'b1));
    end
    $display("test encoders done");
    // Master selection ignored while running, applied once stopped
    auto_run <= 1'b1;
    wr(rcsc_pkg::REG_CTRL, 32'h0000_0020);
    rd(rcsc_pkg::REG_STATUS, v);
    check("virt while run", {31'h0, v[3]}, 32'h0);
    auto_run <= 1'b0;
    repeat (3) @(posedge clk);
    rd(rcsc_pkg::REG_STATUS, v);
    check("virt stopped", {30'h0, v[3], v[0]}, 32'h3);
    // Phase step of 1/16 gives one master count every 16 clocks, 10 over 160
    wr(rcsc_pkg::REG_VM_SPEED, 32'h0000_1000);
    rd(rcsc_pkg::REG_MPOS, v);
    repeat (157) @(posedge clk);
    rd(rcsc_pkg::REG_MPOS, d);
    check("virtual master", d - v, 32'h0000_000A);
    wr(rcsc_pkg::REG_VM_SPEED, rcsc_pkg::SPEED_RST);
    wr(rcsc_pkg::REG_CTRL, 32'h0);
    $display("test master select done");
    // Homing: seek to the cutting pulse edge, then on to the home place
    home_start <= 1'b1;
    @(posedge clk);
    home_start <= 1'b0;
    repeat (40) @(posedge clk);
    cut_pulse <= 1'b1;
    for (int t = 0; t < 5000 && home_done !== 1'b1; t++)
      @(negedge clk);
    check("home_done", {31'h0, home_done}, 32'h1);
    check("sync at cut edge", {31'h0, in_sync_zone}, 32'h1);
    @(posedge clk);
    cut_pulse <= 1'b0;
    trim_fwd <= 1'b1;
    repeat (8) @(posedge clk);
    trim_fwd <= 1'b0;
    @(negedge clk);
    check("home after jog", {31'h0, home_done}, 32'h0);
    $display("test homing done");
    // Roll backs off four counts past a two-count before-cut extent
    wr(rcsc_pkg::REG_ZONE_BEF, 32'h0000_0002);
    run2 <= 1'b1;
    repeat (EDG * GAP) @(posedge clk);
    run2 <= 1'b0;
    repeat (4) @(negedge clk);
    check("sync left", {31'h0, in_sync_zone}, 32'h0);
    wr(rcsc_pkg::REG_ZONE_BEF, rcsc_pkg::ZONE_RST);
    $display("test sync zone done");
    // Linear ramp: jog keeps the error growing, speed climbs one per tick
    wr(rcsc_pkg::REG_CTRL, 32'h0000_0010);
    enable <= 1'b0;
    @(posedge clk);
    enable <= 1'b1;
    trim_fwd <= 1'b1;
    repeat (20) @(posedge clk);
    rd(rcsc_pkg::REG_SPEED_OUT, v);
    repeat (157) @(posedge clk);
    rd(rcsc_pkg::REG_SPEED_OUT, d);
    check("linear ramp", d - v, 32'h0000_0028);
    @(negedge clk);
    check("ana_out2 live", {31'h0, (ana_out2 - d[15:0]) <= 16'h0002}, 32'h1);
    @(posedge clk);
    trim_fwd <= 1'b0;
    $display("test ramp done");
    final_report();
  end
endmodule : tb_top
